// *** sapc_pkg.sv ***
// Package: constants, register map and mode types for acquisition control
package sapc_pkg;
	localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h10;
	localparam logic [7:0] OFS_PERIOD_COUNT = 8'h14;
	localparam logic [7:0] OFS_BIN_DIVIDER = 8'h18;
	localparam logic [7:0] OFS_GROUP_ONE = 8'h20;
	localparam logic [7:0] OFS_GROUP_TWO = 8'h24;
	localparam logic [7:0] OFS_PRESET_EN = 8'h28;
	localparam int BIT_EN_ONE = 0;
	localparam int BIT_LIVE_ONE = 1;
	localparam int BIT_LATCH_ONE = 2;
	localparam int BIT_EN_TWO = 16;
	localparam int BIT_LIVE_TWO = 17;
	localparam int BIT_LATCH_TWO = 18;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [31:0] ONE32 = 32'h0000_0001;
	localparam int MEM_WORDS_LOG2 = 27;
	// 64 MB is 16M words; threshold minus 512 words
	localparam logic [26:0] FULL_LIMIT = 27'h0FF_FE00;
	localparam int CLK_MHZ = 125;
	localparam int MAX_BIN_MHZ = 5;
	localparam int BIN_GAP_CYC = (CLK_MHZ + MAX_BIN_MHZ - 1) / MAX_BIN_MHZ;
	localparam logic [7:0] BIN_GAP = 8'(BIN_GAP_CYC);
	localparam int PIPE_DRAIN = 2;
	localparam logic [1:0] DRAIN_MAX = 2'(PIPE_DRAIN);
	typedef enum logic [1:0] {
		SAPC_SRC_EXT = 2'b00,
		SAPC_SRC_INT = 2'b01,
		SAPC_SRC_CHN = 2'b10,
		SAPC_SRC_OFF = 2'b11
	} sapc_src_t;
	typedef enum logic [1:0] {
		SAPC_IDLE = 2'b00,
		SAPC_RUN = 2'b01,
		SAPC_DONE = 2'b10
	} sapc_state_t;
endpackage

// *** sapc_divider.sv ***
// Bin advance prescaler with rate limiter
`timescale 1ns/1ns
module sapc_divider (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic raw_pulse,
	input wire logic [31:0] divide_by,
	input wire logic sw_pulse,
	output logic advance
);
	import sapc_pkg::*;
	logic [31:0] cnt_r;
	logic [7:0] gap_r;
	logic scaled;
	logic hw_ok;
	// Reload on reaching the programmed value
	assign scaled = (divide_by == ZERO32) ? raw_pulse :
		(raw_pulse && cnt_r >= divide_by);
	assign hw_ok = scaled && gap_r == 8'h00;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_r <= ZERO32;
		end else if (clk_en && raw_pulse) begin
			if (divide_by == ZERO32 || cnt_r >= divide_by) begin
				cnt_r <= ZERO32;
			end else begin
				cnt_r <= cnt_r + ONE32;
			end
		end
	end
	// Minimum spacing before accepted hardware pulses
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			gap_r <= 8'h00;
		end else if (clk_en) begin
			if (hw_ok || sw_pulse) begin
				gap_r <= BIN_GAP - 8'h01;
			end else if (gap_r != 8'h00) begin
				gap_r <= gap_r - 8'h01;
			end
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			advance <= 1'b0;
		end else if (clk_en) begin
			advance <= hw_ok || sw_pulse;
		end
	end
endmodule

// *** sapc_top.sv ***
// Acquisition sequencing, preset compare and memory-full logic
`timescale 1ns/1ns
module sapc_top (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_ack,
	input wire logic key_reset,
	input wire logic key_reset_acq,
	input wire logic key_queue_reset,
	input wire logic key_start,
	input wire logic sw_bin_pulse,
	input wire logic ext_bin_pin,
	input wire logic channel_n_pin,
	input wire logic int_tick,
	input wire sapc_pkg::sapc_src_t src_sel,
	input wire logic non_clearing_mode,
	input wire logic queue_mode,
	input wire logic [31:0] counter_overflow,
	input wire logic [26:0] mem_fill,
	input wire logic [31:0] group_one_sel_count,
	input wire logic [31:0] group_two_sel_count,
	output logic bin_advance_pulse,
	output logic accepted_pulse_monitor,
	output logic mode_enabled,
	output logic acq_done,
	output logic irq_done_edge,
	output logic irq_overflow,
	output logic irq_full_edge,
	output logic mem_full,
	output logic mem_write_block
);
	import sapc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Rising edge of a synchronised level
	function automatic logic rise_of(input logic cur, input logic prev);
		return cur && !prev;
	endfunction
	// Threshold compare for presets and completion
	function automatic logic reached(input logic [31:0] value,
		input logic [31:0] limit);
		return value >= limit;
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_d_r;
	logic ext_rise;
	logic chn_rise;
	logic int_rise;
	logic raw_pulse;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
			pin_d_r <= 3'h0;
		end else if (clk_en) begin
			pin_s1_r <= {int_tick, channel_n_pin, ext_bin_pin};
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
		end
	end
	assign ext_rise = rise_of(pin_s2_r[0], pin_d_r[0]);
	assign chn_rise = rise_of(pin_s2_r[1], pin_d_r[1]);
	assign int_rise = rise_of(pin_s2_r[2], pin_d_r[2]);
	always_comb begin
		case (src_sel)
			SAPC_SRC_EXT: raw_pulse = ext_rise;
			SAPC_SRC_INT: raw_pulse = int_rise;
			SAPC_SRC_CHN: raw_pulse = chn_rise;
			default: raw_pulse = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] period_limit_r;
	logic [31:0] period_count_r;
	logic [31:0] divider_r;
	logic [31:0] group_one_r;
	logic [31:0] group_two_r;
	logic en_one_r;
	logic en_two_r;
	logic latch_one_r;
	logic latch_two_r;
	logic live_one;
	logic live_two;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			period_limit_r <= ZERO32;
			divider_r <= ZERO32;
			group_one_r <= ZERO32;
			group_two_r <= ZERO32;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				OFS_PERIOD_LIMIT: period_limit_r <= reg_wdata;
				OFS_BIN_DIVIDER: divider_r <= reg_wdata;
				OFS_GROUP_ONE: group_one_r <= reg_wdata;
				OFS_GROUP_TWO: group_two_r <= reg_wdata;
				default: ;
			endcase
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			en_one_r <= 1'b0;
			en_two_r <= 1'b0;
		end else if (clk_en) begin
			if (key_reset) begin
				en_one_r <= 1'b0;
				en_two_r <= 1'b0;
			end else if (reg_wr && reg_addr == OFS_PRESET_EN) begin
				en_one_r <= reg_wdata[BIT_EN_ONE];
				en_two_r <= reg_wdata[BIT_EN_TWO];
			end
		end
	end
	assign live_one = en_one_r && reached(group_one_sel_count, group_one_r);
	assign live_two = en_two_r && reached(group_two_sel_count, group_two_r);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			latch_one_r <= 1'b0;
			latch_two_r <= 1'b0;
		end else if (clk_en) begin
			if (key_reset) begin
				latch_one_r <= 1'b0;
				latch_two_r <= 1'b0;
			end else if (bin_advance_pulse) begin
				latch_one_r <= live_one;
				latch_two_r <= live_two;
			end
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			reg_rdata <= ZERO32;
			reg_ack <= 1'b0;
		end else if (clk_en) begin
			reg_ack <= reg_rd || reg_wr;
			reg_rdata <= ZERO32;
			if (reg_rd) begin
				case (reg_addr)
					OFS_PERIOD_LIMIT: reg_rdata <= period_limit_r;
					OFS_PERIOD_COUNT: reg_rdata <= period_count_r;
					OFS_BIN_DIVIDER: reg_rdata <= divider_r;
					OFS_GROUP_ONE: reg_rdata <= group_one_r;
					OFS_GROUP_TWO: reg_rdata <= group_two_r;
					OFS_PRESET_EN: begin
						reg_rdata[BIT_EN_ONE] <= en_one_r;
						reg_rdata[BIT_LIVE_ONE] <= live_one;
						reg_rdata[BIT_LATCH_ONE] <= latch_one_r;
						reg_rdata[BIT_EN_TWO] <= en_two_r;
						reg_rdata[BIT_LIVE_TWO] <= live_two;
						reg_rdata[BIT_LATCH_TWO] <= latch_two_r;
					end
					default: reg_rdata <= ZERO32;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	logic advance;
	logic sw_sync_r;
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sw_sync_r <= 1'b0;
		end else if (clk_en) begin
			sw_sync_r <= sw_bin_pulse;
		end
	end
	sapc_divider u_div (
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.raw_pulse(raw_pulse),
		.divide_by(divider_r),
		.sw_pulse(sw_sync_r),
		.advance(advance)
	);

	// ----------------------------------------
	// Acquisition sequencer
	// ----------------------------------------
	sapc_state_t state_r;
	logic [1:0] drain_r;
	logic accept;
	logic [31:0] count_nxt;
	logic acq_key;
	logic finish;
	assign accept = advance && state_r == SAPC_RUN &&
		(!mem_full || drain_r != 2'h0);
	assign count_nxt = period_count_r + ONE32;
	assign acq_key = key_reset || key_reset_acq;
	// Zero limit never completes
	assign finish = accept && period_limit_r != ZERO32 &&
		reached(count_nxt, period_limit_r);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_r <= SAPC_IDLE;
		end else if (clk_en) begin
			case (state_r)
				SAPC_IDLE: if (key_start) state_r <= SAPC_RUN;
				SAPC_RUN: begin
					if (acq_key) begin
						state_r <= SAPC_IDLE;
					end else if (finish) begin
						state_r <= SAPC_DONE;
					end
				end
				SAPC_DONE: begin
					if (acq_key) begin
						state_r <= SAPC_IDLE;
					end
				end
				default: state_r <= SAPC_IDLE;
			endcase
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			period_count_r <= ZERO32;
		end else if (clk_en) begin
			if (key_start && state_r == SAPC_IDLE) begin
				period_count_r <= ZERO32;
			end else if (accept) begin
				period_count_r <= count_nxt;
			end
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bin_advance_pulse <= 1'b0;
			accepted_pulse_monitor <= 1'b0;
			mode_enabled <= 1'b0;
			acq_done <= 1'b0;
			irq_done_edge <= 1'b0;
		end else if (clk_en) begin
			bin_advance_pulse <= accept;
			accepted_pulse_monitor <= accept;
			mode_enabled <= state_r == SAPC_RUN;
			// Done flag falls with the key, not a cycle later
			acq_done <= state_r == SAPC_DONE && !acq_key;
			irq_done_edge <= finish && !acq_key;
		end
	end

	// ----------------------------------------
	// Overflow and memory almost full
	// ----------------------------------------
	logic full_cond;
	logic queue_clear;
	logic full_nxt;
	assign full_cond = queue_mode && mem_fill > FULL_LIMIT;
	assign queue_clear = key_queue_reset || key_reset;
	// Set wins over a clear in the same cycle
	assign full_nxt = full_cond || (mem_full && !queue_clear);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			irq_overflow <= 1'b0;
		end else if (clk_en) begin
			irq_overflow <= non_clearing_mode &&
				(|counter_overflow);
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mem_full <= 1'b0;
			irq_full_edge <= 1'b0;
			mem_write_block <= 1'b0;
		end else if (clk_en) begin
			irq_full_edge <= full_cond && !mem_full;
			if (full_cond) begin
				mem_full <= 1'b1;
			end else if (queue_clear) begin
				mem_full <= 1'b0;
			end
			// Block drops together with the full flag
			mem_write_block <= full_nxt && drain_r == 2'h0;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			drain_r <= DRAIN_MAX;
		end else if (clk_en) begin
			if (!mem_full) begin
				drain_r <= DRAIN_MAX;
			end else if (accept && drain_r != 2'h0) begin
				drain_r <= drain_r - 2'h1;
			end
		end
	end
endmodule

// *** sapc_asserts.sv ***
// Port checker for the acquisition control block
`timescale 1ns/1ns
module sapc_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire logic key_reset,
	input wire logic key_reset_acq,
	input wire logic key_queue_reset,
	input wire logic non_clearing_mode,
	input wire logic [31:0] counter_overflow,
	input wire logic bin_advance_pulse,
	input wire logic accepted_pulse_monitor,
	input wire logic mode_enabled,
	input wire logic acq_done,
	input wire logic irq_done_edge,
	input wire logic irq_overflow,
	input wire logic irq_full_edge,
	input wire logic mem_full,
	input wire logic mem_write_block
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic [5:0] gap_r;
	// ---------------------------
	// Cycles since last bin pulse
	// ---------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			gap_r <= 6'h3F;
		else if (bin_advance_pulse)
			gap_r <= 6'h00;
		else if (gap_r != 6'h3F)
			gap_r <= gap_r + 6'h01;
	end
	ovf_level_a: assert property (
		(non_clearing_mode && |counter_overflow)[*3] |-> irq_overflow)
		else $error("overflow level missing");
	ovf_mode_a: assert property (
		(!non_clearing_mode)[*3] |-> !irq_overflow)
		else $error("overflow outside non-clearing mode");
	mon_equal_a: assert property (
		accepted_pulse_monitor == bin_advance_pulse)
		else $error("monitor differs from bin pulse");
	bin_gap_a: assert property (
		bin_advance_pulse |-> gap_r >= 6'h18)
		else $error("bin pulses too close");
	done_hold_a: assert property (
		acq_done && !key_reset_acq && !key_reset
		|=> acq_done && !bin_advance_pulse)
		else $error("done released or pulse accepted");
	done_mode_a: assert property (
		acq_done |-> !mode_enabled)
		else $error("mode flag still set when done");
	done_edge_a: assert property (
		irq_done_edge && !key_reset_acq && !key_reset
		|=> acq_done && !irq_done_edge)
		else $error("done edge wrong");
	full_hold_a: assert property (
		mem_full && !key_queue_reset && !key_reset |=> mem_full)
		else $error("full flag dropped");
	full_edge_a: assert property (
		irq_full_edge |-> ##[0:1] mem_full)
		else $error("full edge without full");
	block_full_a: assert property (
		mem_write_block |-> mem_full)
		else $error("write block without full");
	cover property (irq_done_edge);
	cover property (irq_full_edge);
	cover property (irq_overflow);
	cover property (mem_write_block);
endmodule
bind sapc_top sapc_asserts u_chk (.mclk(mclk), .reset(reset),
	.key_reset(key_reset), .key_reset_acq(key_reset_acq),
	.key_queue_reset(key_queue_reset),
	.non_clearing_mode(non_clearing_mode),
	.counter_overflow(counter_overflow),
	.bin_advance_pulse(bin_advance_pulse),
	.accepted_pulse_monitor(accepted_pulse_monitor),
	.mode_enabled(mode_enabled), .acq_done(acq_done),
	.irq_done_edge(irq_done_edge), .irq_overflow(irq_overflow),
	.irq_full_edge(irq_full_edge), .mem_full(mem_full),
	.mem_write_block(mem_write_block));

// *** sapc_pulse_src.sv ***
// Front panel pulse source model
`timescale 1ns/1ns
module sapc_pulse_src (
	input wire logic mclk,
	input wire logic load,
	input wire logic [7:0] n_pulses,
	input wire logic to_chn,
	output logic ext_pin,
	output logic chn_pin
);
	logic [7:0] left_r = 8'h00;
	logic [4:0] ph_r = 5'h00;
	logic hi;
	// ------------------------------
	// One pulse per 30 cycles, idle low
	// ------------------------------
	always @(posedge mclk) begin
		if (load) begin
			left_r <= n_pulses;
			ph_r <= 5'h00;
		end else if (left_r != 8'h00) begin
			ph_r <= (ph_r == 5'h1D) ? 5'h00 : ph_r + 5'h01;
			if (ph_r == 5'h1D)
				left_r <= left_r - 8'h01;
		end
	end
	assign hi = (left_r != 8'h00) && (ph_r < 5'h0A);
	assign ext_pin = hi && !to_chn;
	assign chn_pin = hi && to_chn;
endmodule

// *** sapc_top_tb_top.sv ***
// Testbench for the acquisition control block
`timescale 1ns/1ns
module sapc_top_tb_top;
	import sapc_pkg::*;
	localparam logic [4:0] K_RST = 5'h10, K_ACQ = 5'h08, K_Q = 5'h04;
	localparam logic [4:0] K_ST = 5'h02, K_SW = 5'h01;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0, ovf = 32'h0, cnt1 = 32'h0;
	logic [31:0] cnt2 = 32'h0, reg_rdata;
	logic [4:0] strb = 5'h00;
	logic tick = 1'b0, nc = 1'b0, qm = 1'b0, load = 1'b0, to_chn = 1'b0;
	sapc_src_t src = SAPC_SRC_EXT;
	logic [26:0] fill = 27'h0;
	logic [7:0] npul = 8'h00;
	logic ext_pin, chn_pin, reg_ack, bin_p, mon, mode_en, done;
	logic irq_d, irq_o, irq_f, full, blk;
	logic got_d = 1'b0, got_f = 1'b0;
	int num_errors = 0, n_checks = 0;
	int n_mon = 0, n_bin = 0;
	always #4 mclk = ~mclk;
	always @(posedge mclk) if (irq_d === 1'b1) got_d <= 1'b1;
	always @(posedge mclk) if (irq_f === 1'b1) got_f <= 1'b1;
	always @(posedge mclk) if (mon === 1'b1) n_mon <= n_mon + 1;
	always @(posedge mclk) if (bin_p === 1'b1) n_bin <= n_bin + 1;
	sapc_top dut (.mclk(mclk), .reset(reset), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.key_reset(strb[4]), .key_reset_acq(strb[3]),
		.key_queue_reset(strb[2]), .key_start(strb[1]),
		.sw_bin_pulse(strb[0]), .ext_bin_pin(ext_pin),
		.channel_n_pin(chn_pin), .int_tick(tick), .src_sel(src),
		.non_clearing_mode(nc), .queue_mode(qm), .counter_overflow(ovf),
		.mem_fill(fill), .group_one_sel_count(cnt1),
		.group_two_sel_count(cnt2), .bin_advance_pulse(bin_p),
		.accepted_pulse_monitor(mon), .mode_enabled(mode_en),
		.acq_done(done), .irq_done_edge(irq_d), .irq_overflow(irq_o),
		.irq_full_edge(irq_f), .mem_full(full), .mem_write_block(blk));
	sapc_pulse_src u_src (.mclk(mclk), .load(load), .n_pulses(npul),
		.to_chn(to_chn), .ext_pin(ext_pin), .chn_pin(chn_pin));
	// -----
	// Tasks
	// -----
	task check(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		for (int i = 0; i < 4 && reg_ack !== 1'b1; i++) @(negedge mclk);
		check(reg_rdata, e);
	endtask
	task strobe(input logic [4:0] m);
		@(negedge mclk);
		strb = m;
		@(negedge mclk);
		strb = 5'h00;
	endtask
	task emit(input logic [7:0] n);
		npul = n;
		load = 1'b1;
		idle(1);
		load = 1'b0;
		idle(32 * n + 10);
	endtask
	// -----
	// Tests
	// -----
	task t_regs;
		rdc(OFS_PRESET_EN, 32'h0);
		wr(OFS_PERIOD_LIMIT, 32'hFFFF_FFFF);
		rdc(OFS_PERIOD_LIMIT, 32'hFFFF_FFFF);
		wr(OFS_BIN_DIVIDER, 32'h8000_0001);
		rdc(OFS_BIN_DIVIDER, 32'h8000_0001);
		wr(OFS_GROUP_ONE, 32'h1234_5678);
		wr(OFS_GROUP_TWO, 32'hFFFF_FFFF);
		rdc(OFS_GROUP_ONE, 32'h1234_5678);
		wr(OFS_PERIOD_COUNT, 32'h55);
		rdc(OFS_PERIOD_COUNT, 32'h0);
		rdc(8'h3C, 32'h0);
		wr(OFS_PRESET_EN, 32'h0007_0007);
		rdc(OFS_PRESET_EN, 32'h0001_0001);
		$display("regs done");
	endtask
	task t_acq;
		wr(OFS_BIN_DIVIDER, 32'h0);
		wr(OFS_PERIOD_LIMIT, 32'h3);
		strobe(K_ST);
		idle(1);
		check(mode_en, 1'b1);
		for (int i = 0; i < 4; i++) begin
			strobe(K_SW);
			idle(30);
		end
		rdc(OFS_PERIOD_COUNT, 32'h3);
		check({got_d, done, mode_en}, 3'b110);
		strobe(K_ACQ);
		idle(2);
		check(done, 1'b0);
		$display("acq done");
	endtask
	task t_rate;
		int m0;
		wr(OFS_PERIOD_LIMIT, 32'h0);
		src = SAPC_SRC_INT;
		strobe(K_ST);
		m0 = n_mon;
		for (int i = 0; i < 20; i++) begin
			tick = 1'b1;
			idle(6);
			tick = 1'b0;
			idle(7);
		end
		idle(10);
		rdc(OFS_PERIOD_COUNT, 32'hA);
		check(n_mon - m0, 32'hA);
		$display("rate done");
	endtask
	task t_div;
		strobe(K_ACQ);
		src = SAPC_SRC_EXT;
		wr(OFS_BIN_DIVIDER, 32'h0);
		wr(OFS_BIN_DIVIDER, 32'h3);
		strobe(K_ST);
		emit(8'h0C);
		rdc(OFS_PERIOD_COUNT, 32'h3);
		strobe(K_ACQ);
		src = SAPC_SRC_CHN;
		to_chn = 1'b1;
		wr(OFS_BIN_DIVIDER, 32'h0);
		strobe(K_ST);
		emit(8'h04);
		rdc(OFS_PERIOD_COUNT, 32'h4);
		src = SAPC_SRC_OFF;
		emit(8'h02);
		rdc(OFS_PERIOD_COUNT, 32'h4);
		to_chn = 1'b0;
		$display("div done");
	endtask
	task t_preset;
		wr(OFS_GROUP_ONE, 32'd100);
		wr(OFS_GROUP_TWO, 32'd200);
		wr(OFS_PRESET_EN, 32'h0001_0001);
		cnt1 = 32'd150;
		cnt2 = 32'd50;
		idle(3);
		rdc(OFS_PRESET_EN, 32'h0001_0003);
		strobe(K_SW);
		idle(30);
		cnt2 = 32'd200;
		idle(3);
		rdc(OFS_PRESET_EN, 32'h0003_0007);
		strobe(K_RST);
		idle(3);
		rdc(OFS_PRESET_EN, 32'h0);
		$display("preset done");
	endtask
	task t_ovf;
		ovf = 32'h8000_0020;
		idle(4);
		check(irq_o, 1'b0);
		nc = 1'b1;
		idle(4);
		check(irq_o, 1'b1);
		ovf = 32'h0;
		idle(4);
		check(irq_o, 1'b0);
		nc = 1'b0;
		$display("ovf done");
	endtask
	task t_full;
		int b0;
		qm = 1'b1;
		fill = FULL_LIMIT;
		idle(4);
		check(full, 1'b0);
		got_f = 1'b0;
		fill = FULL_LIMIT + 27'h1;
		idle(4);
		check({full, got_f}, 2'b11);
		fill = 27'h0;
		wr(OFS_PERIOD_LIMIT, 32'h0);
		strobe(K_ST);
		b0 = n_bin;
		for (int i = 0; i < 4; i++) begin
			strobe(K_SW);
			idle(30);
		end
		check({full, blk}, 2'b11);
		check(n_bin - b0, 32'h2);
		rdc(OFS_PERIOD_COUNT, 32'h2);
		strobe(K_Q);
		idle(3);
		check(full, 1'b0);
		qm = 1'b0;
		$display("full done");
	endtask
	task conclude;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		idle(3);
		reset = 1'b0;
		t_regs;
		t_acq;
		t_rate;
		t_div;
		t_preset;
		t_ovf;
		t_full;
		conclude;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		conclude;
	end
endmodule
